// [src/pin_change_interrupt.sv]
// pin change interrupt: three full ports, one pin of a fourth, register port
`timescale 1ns/100ps
`include "pin_change_regs.svh"
module pin_change_interrupt
  import pin_change_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [WIDTH-1:0] port_a_i,
  input wire logic [WIDTH-1:0] port_b_i,
  input wire logic [WIDTH-1:0] port_c_i,
  input wire logic port_e_pin_three_i,
  input wire logic ext_reset_pin_enable_i,
  input wire logic low_voltage_program_enable_i,
  input wire logic [`PC_ADDR_W-1:0] addr_i,
  input wire logic [`PC_DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [`PC_DATA_W-1:0] rdata_o,
  output logic change_irq_o,
  output logic wake_o,
  output logic irq_o
);
  localparam logic [WIDTH-1:0] E_MASK = WIDTH'(1) << `PC_E_PIN;

  // strap levels, synchronised before use
  logic [1:0] strap_meta_r;
  logic [1:0] strap_sync_r;
  logic e_avail_w;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      strap_meta_r <= 2'h0;
      strap_sync_r <= 2'h0;
    end else begin
      strap_meta_r <= {ext_reset_pin_enable_i, low_voltage_program_enable_i};
      strap_sync_r <= strap_meta_r;
    end
  end

  // pin serving as reset or programming input: no detection
  assign e_avail_w = ~(|strap_sync_r);

  // write decode
  wire we_a_rise = wr_i && addr_i == `PC_A_RISE;
  wire we_a_fall = wr_i && addr_i == `PC_A_FALL;
  wire we_a_flag = wr_i && addr_i == `PC_A_FLAG;
  wire we_b_rise = wr_i && addr_i == `PC_B_RISE;
  wire we_b_fall = wr_i && addr_i == `PC_B_FALL;
  wire we_b_flag = wr_i && addr_i == `PC_B_FLAG;
  wire we_c_rise = wr_i && addr_i == `PC_C_RISE;
  wire we_c_fall = wr_i && addr_i == `PC_C_FALL;
  wire we_c_flag = wr_i && addr_i == `PC_C_FLAG;
  wire we_e_rise = wr_i && addr_i == `PC_E_RISE;
  wire we_e_fall = wr_i && addr_i == `PC_E_FALL;
  wire we_e_flag = wr_i && addr_i == `PC_E_FLAG;
  wire we_ctrl = wr_i && addr_i == `PC_CTRL;
  wire we_mask = wr_i && addr_i == `PC_IRQ_MASK;
  wire rd_stat = rd_i && addr_i == `PC_IRQ_STAT;

  logic [WIDTH-1:0] a_rise, a_fall, a_flag;
  logic [WIDTH-1:0] b_rise, b_fall, b_flag;
  logic [WIDTH-1:0] c_rise, c_fall, c_flag;
  logic [WIDTH-1:0] e_rise, e_fall, e_flag;
  logic a_edge, b_edge, c_edge, e_edge;
  logic [WIDTH-1:0] all_avail_w;
  logic [WIDTH-1:0] e_pins_w;

  assign all_avail_w = '1;
  assign e_pins_w = WIDTH'(port_e_pin_three_i) << `PC_E_PIN;

  pin_change_port #(.WIDTH(WIDTH)) u_port_a (
    .clk_i(clk_i), .rstn_i(rstn_i), .pin_i(port_a_i),
    .avail_i(all_avail_w), .rise_we_i(we_a_rise), .fall_we_i(we_a_fall),
    .flag_we_i(we_a_flag), .wdata_i(wdata_i),
    .rise_en_o(a_rise), .fall_en_o(a_fall), .flag_o(a_flag),
    .edge_o(a_edge)
  );
  pin_change_port #(.WIDTH(WIDTH)) u_port_b (
    .clk_i(clk_i), .rstn_i(rstn_i), .pin_i(port_b_i),
    .avail_i(all_avail_w), .rise_we_i(we_b_rise), .fall_we_i(we_b_fall),
    .flag_we_i(we_b_flag), .wdata_i(wdata_i),
    .rise_en_o(b_rise), .fall_en_o(b_fall), .flag_o(b_flag),
    .edge_o(b_edge)
  );
  pin_change_port #(.WIDTH(WIDTH)) u_port_c (
    .clk_i(clk_i), .rstn_i(rstn_i), .pin_i(port_c_i),
    .avail_i(all_avail_w), .rise_we_i(we_c_rise), .fall_we_i(we_c_fall),
    .flag_we_i(we_c_flag), .wdata_i(wdata_i),
    .rise_en_o(c_rise), .fall_en_o(c_fall), .flag_o(c_flag),
    .edge_o(c_edge)
  );
  // only pin three exists on port e
  pin_change_port #(.WIDTH(WIDTH), .PIN_MASK(E_MASK)) u_port_e (
    .clk_i(clk_i), .rstn_i(rstn_i), .pin_i(e_pins_w),
    .avail_i({WIDTH{e_avail_w}}), .rise_we_i(we_e_rise),
    .fall_we_i(we_e_fall), .flag_we_i(we_e_flag), .wdata_i(wdata_i),
    .rise_en_o(e_rise), .fall_en_o(e_fall), .flag_o(e_flag),
    .edge_o(e_edge)
  );

  // master enable and system interrupt registers
  logic master_r;
  logic [`PC_EVT_W-1:0] stat_r;
  logic [`PC_EVT_W-1:0] stat_nxt;
  logic [`PC_EVT_W-1:0] mask_r;
  logic [`PC_EVT_W-1:0] evt_w;
  logic summary_w;

  // summary is the or of every per-pin flag
  assign summary_w = |{a_flag, b_flag, c_flag, e_flag};
  assign evt_w = {e_edge, c_edge, b_edge, a_edge};
  // read clears, but an event in the same cycle wins
  assign stat_nxt = (rd_stat ? `PC_EVT_W'(0) : stat_r) | evt_w;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      master_r <= 1'b0;
      stat_r <= '0;
      mask_r <= '0;
    end else begin
      if (we_ctrl) master_r <= wdata_i[`PC_MASTER_BIT];
      if (we_mask) mask_r <= wdata_i[`PC_EVT_W-1:0];
      stat_r <= stat_nxt;
    end
  end

  // read mux, registered so data stands the cycle after the strobe
  logic [`PC_DATA_W-1:0] rmux_w;
  always_comb begin
    case (addr_i)
      `PC_A_RISE: rmux_w = a_rise;
      `PC_A_FALL: rmux_w = a_fall;
      `PC_A_FLAG: rmux_w = a_flag;
      `PC_B_RISE: rmux_w = b_rise;
      `PC_B_FALL: rmux_w = b_fall;
      `PC_B_FLAG: rmux_w = b_flag;
      `PC_C_RISE: rmux_w = c_rise;
      `PC_C_FALL: rmux_w = c_fall;
      `PC_C_FLAG: rmux_w = c_flag;
      `PC_E_RISE: rmux_w = e_rise;
      `PC_E_FALL: rmux_w = e_fall;
      `PC_E_FLAG: rmux_w = e_flag;
      `PC_CTRL: rmux_w = `PC_DATA_W'(master_r);
      `PC_SUMMARY: rmux_w = `PC_DATA_W'(summary_w);
      `PC_IRQ_STAT: rmux_w = `PC_DATA_W'(stat_r);
      `PC_IRQ_MASK: rmux_w = `PC_DATA_W'(mask_r);
      default: rmux_w = `PC_ZERO8;
    endcase
  end

  // outputs straight from flops; flags feed change_irq_o and wake_o one cycle after setting
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= `PC_ZERO8;
      change_irq_o <= 1'b0;
      wake_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      rdata_o <= rd_i ? rmux_w : `PC_ZERO8;
      change_irq_o <= master_r & summary_w;
      wake_o <= master_r & summary_w;
      irq_o <= |(stat_nxt & mask_r);
    end
  end

  // assertions: request path first, since it is what software sees
  a_irq_gated: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    change_irq_o |-> $past(master_r))
    else $error("change irq without master enable");

  a_master_off: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    !master_r |=> !change_irq_o)
    else $error("change irq while master enable off");

  // detection keeps running with the master enable off
  a_detect_unmasked: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (!master_r && u_port_b.hit_w[7]) |=> b_flag[7])
    else $error("flag not set with master enable off");

  a_irq_follows: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (master_r && summary_w) |=> change_irq_o)
    else $error("change irq missing");

  // edge, then flag, then request and wake one edge later
  sequence s_a0_rise_armed;
    a_rise[0] && u_port_a.rise_w[0] && master_r && !we_ctrl;
  endsequence
  sequence s_flag_then_req;
    a_flag[0] ##1 (change_irq_o && wake_o);
  endsequence
  a_edge_to_wake: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    s_a0_rise_armed |=> s_flag_then_req)
    else $error("edge did not reach request and wake");

  a_summary_or: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    summary_w == (|a_flag || |b_flag || |c_flag || |e_flag))
    else $error("summary not or of flags");

  // the summary register shows the flags of the read cycle
  a_summary_read: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (rd_i && addr_i == `PC_SUMMARY)
      |=> rdata_o == `PC_DATA_W'($past(summary_w)))
    else $error("summary register differs from flags");

  a_flag_sticky: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (a_flag[0] && !we_a_flag) |=> a_flag[0])
    else $error("flag dropped without write");

  a_clear_zero: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (we_a_flag && !wdata_i[0] && !u_port_a.hit_w[0]) |=> !a_flag[0])
    else $error("zero write did not clear flag");

  a_edge_wins: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (we_a_flag && u_port_a.hit_w[0]) |=> a_flag[0])
    else $error("edge lost during clear");

  sequence s_rise_seen;
    a_rise[2] && u_port_a.rise_w[2];
  endsequence
  a_rise_flags: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    s_rise_seen |=> a_flag[2])
    else $error("enabled rising edge not flagged");

  // no enable at all: a clear flag must stay clear
  a_rise_off: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (!a_rise[0] && !a_fall[0] && !a_flag[0]) |=> !a_flag[0])
    else $error("flag set with both enables off");

  // a new flag needs an enabled edge behind it
  a_fall_off: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    $rose(b_flag[7]) |-> $past((b_fall[7] && u_port_b.fall_w[7]) ||
                              (b_rise[7] && u_port_b.rise_w[7])))
    else $error("flag set without enable");

  a_both_dirs: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (c_rise[0] && c_fall[0] && (u_port_c.rise_w[0] || u_port_c.fall_w[0]))
      |=> c_flag[0])
    else $error("edge not flagged with both enables set");

  a_e_only_pin: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (e_flag & ~E_MASK) == '0)
    else $error("port e flag outside pin three");

  a_e_blocked: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    !e_avail_w |-> !u_port_e.edge_o)
    else $error("pin e3 detected while unavailable");

  // status register: events set, a read clears, set beats clear
  a_stat_sets: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (evt_w != '0) |=> (stat_r & $past(evt_w)) == $past(evt_w))
    else $error("port event lost in status");

  a_stat_clears: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (rd_stat && evt_w == '0) |=> stat_r == '0)
    else $error("status not cleared by read");

  // mask writes shift the level by one edge, so skip that edge
  a_irq_level: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    !$past(we_mask) |-> irq_o == |(stat_r & mask_r))
    else $error("irq level differs from masked status");

  a_rdata_idle: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    !$past(rd_i) |-> rdata_o == `PC_ZERO8)
    else $error("read data outside the read answer cycle");
endmodule

// [shared/pin_change_regs.svh]
// register offsets, field positions and reset values of the pin change block
`ifndef PIN_CHANGE_REGS_SVH
`define PIN_CHANGE_REGS_SVH

`define PC_ADDR_W 4
`define PC_DATA_W 8
// per-port register triplets: rising enable, falling enable, flags
`define PC_A_RISE 4'h0
`define PC_A_FALL 4'h1
`define PC_A_FLAG 4'h2
`define PC_B_RISE 4'h3
`define PC_B_FALL 4'h4
`define PC_B_FLAG 4'h5
`define PC_C_RISE 4'h6
`define PC_C_FALL 4'h7
`define PC_C_FLAG 4'h8
`define PC_E_RISE 4'h9
`define PC_E_FALL 4'hA
`define PC_E_FLAG 4'hB
// control: bit 0 master enable; summary: bit 0 summary flag
`define PC_CTRL 4'hC
`define PC_SUMMARY 4'hD
`define PC_IRQ_STAT 4'hE
`define PC_IRQ_MASK 4'hF
`define PC_MASTER_BIT 0
`define PC_SUMMARY_BIT 0
`define PC_E_PIN 3
`define PC_ZERO8 8'h00
`define PC_EVT_W 4

`endif

// [shared/pin_change_pkg.sv]
// types shared by the pin change block
package pin_change_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [1:0] {
    PORT_A,
    PORT_B,
    PORT_C,
    PORT_E
  } port_sel_t;
endpackage

// [src/pin_sync.sv]
// two-flop synchroniser plus previous sample for edge detection
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] rise_o,
  output logic [WIDTH-1:0] fall_o
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] prev_r;

  // first stage feeds only the second; prev_r is the last sample
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
    end else begin
      meta_r <= pin_i;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // edge = current sample against the previous one
  assign rise_o = sync_r & ~prev_r;
  assign fall_o = ~sync_r & prev_r;
endmodule

// [src/pin_change_port.sv]
// one port: edge enables and sticky per-pin flags
`timescale 1ns/100ps
module pin_change_port
  import pin_change_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] PIN_MASK = '1
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [WIDTH-1:0] pin_i,
  input wire logic [WIDTH-1:0] avail_i,
  input wire logic rise_we_i,
  input wire logic fall_we_i,
  input wire logic flag_we_i,
  input wire logic [WIDTH-1:0] wdata_i,
  output logic [WIDTH-1:0] rise_en_o,
  output logic [WIDTH-1:0] fall_en_o,
  output logic [WIDTH-1:0] flag_o,
  output logic edge_o
);
  logic [WIDTH-1:0] rise_w;
  logic [WIDTH-1:0] fall_w;
  logic [WIDTH-1:0] hit_w;
  logic [WIDTH-1:0] flag_nxt;
  logic [WIDTH-1:0] rise_en_r;
  logic [WIDTH-1:0] fall_en_r;
  logic [WIDTH-1:0] flag_r;

  pin_sync #(.WIDTH(WIDTH)) u_sync (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .pin_i(pin_i),
    .rise_o(rise_w),
    .fall_o(fall_w)
  );

  // two independent detectors per pin, either direction may flag
  assign hit_w = ((rise_w & rise_en_r) | (fall_w & fall_en_r))
                 & PIN_MASK & avail_i;
  // a write may only clear; a fresh edge always wins
  assign flag_nxt = (flag_we_i ? (flag_r & wdata_i) : flag_r) | hit_w;
  assign edge_o = |hit_w;

  // enables and flags all clear on reset
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rise_en_r <= '0;
      fall_en_r <= '0;
      flag_r <= '0;
    end else begin
      if (rise_we_i) rise_en_r <= wdata_i & PIN_MASK;
      if (fall_we_i) fall_en_r <= wdata_i & PIN_MASK;
      flag_r <= flag_nxt & PIN_MASK;
    end
  end

  assign rise_en_o = rise_en_r;
  assign fall_en_o = fall_en_r;
  assign flag_o = flag_r;
endmodule

// [tb/pin_source.sv]
// behavioural model of the outside signals on the watched port pins
`timescale 1ns/100ps
module pin_source (
  input wire logic clk_i,
  output logic [7:0] port_a_o,
  output logic [7:0] port_b_o,
  output logic [7:0] port_c_o,
  output logic port_e_pin_three_o
);
  // pins start low; each level is held for clocks, since shorter pulses
  // may slip between samples
  initial begin
    port_a_o = 8'h00;
    port_b_o = 8'h00;
    port_c_o = 8'h00;
    port_e_pin_three_o = 1'b0;
  end
  // one port changes just after an edge; the e pin follows bit 3
  task automatic set_port(input int p, input logic [7:0] v);
    @(posedge clk_i);
    case (p)
      0: port_a_o <= v;
      1: port_b_o <= v;
      2: port_c_o <= v;
      default: port_e_pin_three_o <= v[3];
    endcase
  endtask
endmodule

// [tb/tb_pin_change_interrupt.sv]
// self-checking bench for the pin change interrupt block
`timescale 1ns/100ps
`include "pin_change_regs.svh"
module tb_pin_change_interrupt;
  import pin_change_pkg::*;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [7:0] pa, pb, pc;
  logic pe3;
  logic reset_strap = 1'b0;
  logic prog_strap = 1'b0;
  logic [3:0] addr_i = 4'h0;
  byte_t wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  byte_t rdata_o;
  logic change_irq_o, wake_o, irq_o;
  int mismatches = 0;
  int compares = 0;

  // 20 MHz system clock
  always #25 clk_i = ~clk_i;

  pin_source pin_source_inst (.clk_i(clk_i), .port_a_o(pa), .port_b_o(pb),
    .port_c_o(pc), .port_e_pin_three_o(pe3));
  pin_change_interrupt pin_change_interrupt_inst (.clk_i(clk_i),
    .rstn_i(rstn_i), .port_a_i(pa), .port_b_i(pb), .port_c_i(pc),
    .port_e_pin_three_i(pe3), .ext_reset_pin_enable_i(reset_strap),
    .low_voltage_program_enable_i(prog_strap), .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .change_irq_o(change_irq_o), .wake_o(wake_o), .irq_o(irq_o));

  task automatic end_of_test();
    if (mismatches == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] seen,
                     input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic wr(input logic [3:0] a, input byte_t v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rchk(input string what, input logic [3:0] a,
                      input byte_t exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    chk(what, rdata_o, exp);
  endtask

  // four edges cover sync, compare, flag and request stages
  task automatic pins(input int p, input byte_t v);
    pin_source_inst.set_port(p, v);
    tick(4);
  endtask

  task automatic s_reset();
    for (int i = 0; i < 16; i++) begin
      rchk("reg", 4'(i), 8'h00);
    end
    chk("irq", 8'(irq_o), 8'h00);
  endtask

  task automatic s_edges();
    wr(`PC_A_RISE, 8'h05);
    pins(0, 8'h05);
    rchk("flag a", `PC_A_FLAG, 8'h05);
    pins(0, 8'h00);
    rchk("flag a", `PC_A_FLAG, 8'h05);
    wr(`PC_A_FLAG, 8'h00);
    rchk("flag a", `PC_A_FLAG, 8'h00);
    wr(`PC_B_FALL, 8'h80);
    pins(1, 8'h80);
    rchk("flag b", `PC_B_FLAG, 8'h00);
    pins(1, 8'h00);
    rchk("flag b", `PC_B_FLAG, 8'h80);
    wr(`PC_C_RISE, 8'h01);
    wr(`PC_C_FALL, 8'h01);
    pins(2, 8'h01);
    rchk("flag c", `PC_C_FLAG, 8'h01);
    wr(`PC_C_FLAG, 8'h00);
    pins(2, 8'h00);
    rchk("flag c", `PC_C_FLAG, 8'h01);
    rchk("summary", `PC_SUMMARY, 8'h01);
    chk("change irq", 8'(change_irq_o), 8'h00);
    wr(`PC_CTRL, 8'h01);
    tick(2);
    @(negedge clk_i);
    chk("change irq", 8'(change_irq_o), 8'h01);
    chk("wake", 8'(wake_o), 8'h01);
    // software clears only the bits it has seen
    wr(`PC_B_FLAG, 8'h7F);
    rchk("flag b", `PC_B_FLAG, 8'h00);
    chk("change irq", 8'(change_irq_o), 8'h01);
    wr(`PC_C_FLAG, 8'hFE);
    tick(2);
    @(negedge clk_i);
    chk("change irq", 8'(change_irq_o), 8'h00);
    wr(`PC_SUMMARY, 8'h01);
    rchk("summary", `PC_SUMMARY, 8'h00);
  endtask

  // the clearing write lands on the edge that sets the flag
  task automatic s_race();
    pin_source_inst.set_port(0, 8'h01);
    tick(1);
    wr(`PC_A_FLAG, 8'h00);
    rchk("flag a", `PC_A_FLAG, 8'h01);
    wr(`PC_A_FLAG, 8'h00);
  endtask

  task automatic s_e3();
    wr(`PC_E_RISE, 8'hFF);
    rchk("rise e", `PC_E_RISE, 8'h08);
    @(posedge clk_i);
    reset_strap <= 1'b1;
    tick(3);
    pins(3, 8'h08);
    rchk("flag e", `PC_E_FLAG, 8'h00);
    pins(3, 8'h00);
    reset_strap <= 1'b0;
    prog_strap <= 1'b1;
    tick(3);
    pins(3, 8'h08);
    rchk("flag e", `PC_E_FLAG, 8'h00);
    pins(3, 8'h00);
    prog_strap <= 1'b0;
    tick(3);
    pins(3, 8'h08);
    rchk("flag e", `PC_E_FLAG, 8'h08);
  endtask

  // status is sticky per port, cleared by reading, gated by the mask
  task automatic s_irq();
    rchk("status", `PC_IRQ_STAT, 8'h0F);
    rchk("status", `PC_IRQ_STAT, 8'h00);
    wr(`PC_IRQ_MASK, 8'h01);
    pins(1, 8'h80);
    pins(1, 8'h00);
    @(negedge clk_i);
    chk("irq", 8'(irq_o), 8'h00);
    pins(0, 8'h05);
    @(negedge clk_i);
    chk("irq", 8'(irq_o), 8'h01);
    rchk("status", `PC_IRQ_STAT, 8'h03);
    tick(1);
    @(negedge clk_i);
    chk("irq", 8'(irq_o), 8'h00);
  endtask

  // a hang counts as a mismatch
  initial begin
    #500000;
    mismatches++;
    end_of_test();
  end

  // reset for four cycles, then the scenarios in turn
  initial begin
    tick(4);
    rstn_i <= 1'b1;
    s_reset();
    s_edges();
    s_race();
    s_e3();
    s_irq();
    end_of_test();
  end
endmodule
